/* File: rtl/usb_endpoint_mode_count_regs.sv */
// Contract
// RULE1 - Non-control mode: stall bit 7, reserved 6:5, ack 4, mode 3:0, reset zero.
// RULE2 - Engine sets ack flag when a transaction to the endpoint ends with ACK.
// RULE3 - Firmware writes zeros into the reserved mode bits.
// RULE4 - Stall bit stalls OUT in ack-in mode and IN in ack-out mode.
// RULE5 - Firmware keeps stall bit clear in all other modes.
// RULE6 - Five counters: toggle bit 7, data valid bit 6, count 5:0, reset zero.
// RULE7 - In five-endpoint configuration endpoint_mode_alt_ep3 is non-control endpoint 3.
// RULE8 - Firmware loads IN byte count with 0 to 32.
// RULE9 - After OUT or SETUP hardware writes received bytes plus two CRC bytes.
// RULE10 - Good CRC sets data valid; bad CRC clears it but still interrupts.
// RULE11 - Toggle 0 is DATA0, 1 is DATA1; hardware writes received toggle.
// RULE12 - Endpoint 0 counter locks after SETUP or OUT until CPU read.
// RULE13 - SETUP forces setup bit high until control write data phase ends.
// RULE14 - Read unlocks endpoint 0 registers only after the UPDATE point.
// RULE15 - At UPDATE all mode bits but setup bit and all counter bits rewrite; code rewrites the counter only after OUT or SETUP, never after IN.
// RULE16 - Endpoint interrupt flag sets at UPDATE, not earlier.
// RULE17 - At UPDATE endpoint 0 mode and counter registers become locked; code locks the counter only at an OUT or SETUP update.
// RULE18 - Firmware reads endpoint 0 registers in its service routine to unlock.
// RULE19 - Ack-out-status-in exists, no ack-out-nak-in; next SETUP may overwrite data.
// RULE20 - Ack-out 1001 and ack-in 1101 become 1000 and 1100 after ACK.
// RULE21 - CPU write to a locked endpoint 0 register is discarded entirely.
`timescale 1ns/100ps
`include "usb_epregs_defs.svh"

module usb_endpoint_mode_count_regs #(
    parameter int NUM_EP = 5
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [9:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [9:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic sie_setup_i,
    input wire logic sie_data_end_i,
    input wire logic sie_update_i,
    input wire logic [2:0] sie_ep_i,
    input wire usb_epregs_pkg::sie_token_type sie_token_i,
    input wire logic sie_ack_i,
    input wire logic sie_crc_ok_i,
    input wire logic [5:0] sie_rx_bytes_i,
    input wire logic sie_rx_toggle_i,
    input wire logic sie_irq_i,
    output logic [8*NUM_EP-1:0] ep_mode_o,
    output logic [8*NUM_EP-1:0] ep_count_o,
    output logic [NUM_EP-1:0] stall_in_o,
    output logic [NUM_EP-1:0] stall_out_o,
    output logic [NUM_EP-1:0] ep_irq_flag_o,
    output logic five_ep_o
);

    logic [7:0] mode_q [NUM_EP];
    logic [7:0] count_q [NUM_EP];
    logic [7:0] cfg_q;
    logic [NUM_EP-1:0] irq_q;
    logic [NUM_EP-1:0] mode_lock_q;
    logic [NUM_EP-1:0] count_lock_q;
    logic [NUM_EP-1:0] setup_force_q;
    logic [NUM_EP-1:0] update_pending_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic aw_held_q;
    logic w_held_q;
    logic [9:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wstrb0_q;

    // Decode a byte address into register kind and endpoint slot
    function automatic usb_epregs_pkg::reg_sel_type decode(input logic [9:0] addr);
        usb_epregs_pkg::reg_sel_type sel;
        sel.kind = usb_epregs_pkg::reg_none;
        sel.slot = 3'h0;
        if (addr[1:0] == 2'h0)
        begin
            unique case (addr[9:2])
                `EPR_IDX_COUNT_A: sel = '{usb_epregs_pkg::reg_count, 3'h0};
                `EPR_IDX_COUNT_B: sel = '{usb_epregs_pkg::reg_count, 3'h1};
                `EPR_IDX_COUNT_C: sel = '{usb_epregs_pkg::reg_count, 3'h2};
                `EPR_IDX_COUNT_D: sel = '{usb_epregs_pkg::reg_count, 3'h3};
                `EPR_IDX_COUNT_E: sel = '{usb_epregs_pkg::reg_count, 3'h4};
                `EPR_IDX_MODE_EP0: sel = '{usb_epregs_pkg::reg_mode, 3'h0};
                `EPR_IDX_MODE_A: sel = '{usb_epregs_pkg::reg_mode, 3'h1};
                `EPR_IDX_MODE_B: sel = '{usb_epregs_pkg::reg_mode, 3'h2};
                `EPR_IDX_MODE_ALT_EP3: sel = '{usb_epregs_pkg::reg_mode, 3'h3};
                `EPR_IDX_MODE_C: sel = '{usb_epregs_pkg::reg_mode, 3'h4};
                `EPR_IDX_CONFIG: sel = '{usb_epregs_pkg::reg_config, 3'h0};
                `EPR_IDX_IRQ_FLAGS: sel = '{usb_epregs_pkg::reg_irq, 3'h0};
                default: sel.kind = usb_epregs_pkg::reg_none;
            endcase
        end
        return sel;
    endfunction

    // Slot 0 is always control; slot 3 only outside five-endpoint operation
    function automatic logic is_control(input logic [2:0] slot, input logic five);
        return (slot == 3'h0) || ((slot == 3'h3) && !five); // see RULE7
    endfunction

    logic five_ep;
    logic do_write;
    logic do_read;
    usb_epregs_pkg::reg_sel_type wsel;
    usb_epregs_pkg::reg_sel_type rsel;
    logic rx_token;

    assign five_ep = cfg_q[`EPR_CFG_FIVE_EP_BIT];
    assign do_write = aw_held_q && w_held_q && !bvalid_q;
    assign do_read = s_axi_arvalid_i && arready_q;
    assign wsel = decode(awaddr_q);
    assign rsel = decode(s_axi_araddr_i);
    assign rx_token = (sie_token_i == usb_epregs_pkg::token_out)
        || (sie_token_i == usb_epregs_pkg::token_setup);

    // Write address and data are taken independently, in either order
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 10'h000;
            wdata_q <= 8'h00;
            wstrb0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `EPR_RESP_OKAY;
        end
        else if (ce_i)
        begin
            if (s_axi_awvalid_i && awready_q)
            begin
                awaddr_q <= s_axi_awaddr_i;
                aw_held_q <= 1'b1;
                awready_q <= 1'b0;
            end
            if (s_axi_wvalid_i && wready_q)
            begin
                wdata_q <= s_axi_wdata_i[7:0];
                wstrb0_q <= s_axi_wstrb_i[0];
                w_held_q <= 1'b1;
                wready_q <= 1'b0;
            end
            if (do_write)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= (wsel.kind == usb_epregs_pkg::reg_none)
                    ? `EPR_RESP_SLVERR : `EPR_RESP_OKAY;
            end
            if (bvalid_q && s_axi_bready_i)
            begin
                bvalid_q <= 1'b0;
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // Read data is captured at the address handshake, so side effects occur there
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `EPR_RESP_OKAY;
        end
        else if (ce_i)
        begin
            if (do_read)
            begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rresp_q <= `EPR_RESP_OKAY;
                unique case (rsel.kind)
                    usb_epregs_pkg::reg_mode: rdata_q <= {24'h000000, mode_q[rsel.slot]};
                    usb_epregs_pkg::reg_count: rdata_q <= {24'h000000, count_q[rsel.slot]};
                    usb_epregs_pkg::reg_config: rdata_q <= {24'h000000, cfg_q};
                    usb_epregs_pkg::reg_irq: rdata_q <= {27'h0000000, irq_q};
                    usb_epregs_pkg::reg_none:
                    begin
                        rdata_q <= 32'h0000_0000;
                        rresp_q <= `EPR_RESP_SLVERR;
                    end
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
            else if (rvalid_q && s_axi_rready_i)
            begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            cfg_q <= `EPR_CFG_RESET;
        end
        else if (ce_i && do_write && wstrb0_q && wsel.kind == usb_epregs_pkg::reg_config)
        begin
            cfg_q <= {wdata_q[7:6], 6'h00};
        end
    end

    // Mode registers: engine update wins over a CPU write in the same cycle
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            for (int e = 0; e < NUM_EP; e++)
            begin
                mode_q[e] <= `EPR_MODE_RESET; // see RULE1
            end
        end
        else if (ce_i)
        begin
            for (int e = 0; e < NUM_EP; e++)
            begin
                if (sie_update_i && sie_ep_i == 3'(e))
                begin
                    // Setup bit and stall/reserved bits of other slots are carried over
                    if (sie_token_i == usb_epregs_pkg::token_setup)
                    begin
                        mode_q[e][3:0] <= `EPR_MODE_NAK_INOUT; // see RULE15 RULE19
                    end
                    else if (sie_ack_i && mode_q[e][3] && mode_q[e][0])
                    begin
                        // 1001, 1011, 1101, 1111 fall back to their NAK forms
                        mode_q[e][3:0] <= {mode_q[e][3:1], 1'b0}; // see RULE20
                    end
                    if (sie_ack_i)
                    begin
                        mode_q[e][`EPR_MODE_ACK_BIT] <= 1'b1; // see RULE2
                    end
                    if (is_control(3'(e), five_ep))
                    begin
                        mode_q[e][`EPR_MODE_IN_RX_BIT] <= sie_token_i == usb_epregs_pkg::token_in;
                        mode_q[e][`EPR_MODE_OUT_RX_BIT] <=
                            sie_token_i == usb_epregs_pkg::token_out; // see RULE15
                    end
                end
                else if (do_write && wstrb0_q && wsel.kind == usb_epregs_pkg::reg_mode
                    && wsel.slot == 3'(e) && !mode_lock_q[e]) // see RULE21
                begin
                    if (is_control(3'(e), five_ep))
                    begin
                        mode_q[e][6:0] <= wdata_q[6:0];
                    end
                    else
                    begin
                        // Reserved bits stored as written; firmware keeps them zero
                        mode_q[e] <= wdata_q; // see RULE3
                    end
                end
                if (is_control(3'(e), five_ep))
                begin
                    if (sie_setup_i && sie_ep_i == 3'(e))
                    begin
                        mode_q[e][`EPR_MODE_SETUP_BIT] <= 1'b1; // see RULE13
                    end
                    else if (do_write && wstrb0_q && wsel.kind == usb_epregs_pkg::reg_mode
                        && wsel.slot == 3'(e) && !mode_lock_q[e] && !setup_force_q[e])
                    begin
                        // A CPU write while unlocked and outside the setup force window clears the setup bit, never sets it
                        mode_q[e][`EPR_MODE_SETUP_BIT] <= 1'b0; // see RULE13
                    end
                end
            end
        end
    end

    // Counter registers
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            for (int e = 0; e < NUM_EP; e++)
            begin
                count_q[e] <= `EPR_CNT_RESET; // see RULE6
            end
        end
        else if (ce_i)
        begin
            for (int e = 0; e < NUM_EP; e++)
            begin
                if (sie_update_i && sie_ep_i == 3'(e) && rx_token)
                begin
                    count_q[e][`EPR_CNT_TOGGLE_BIT] <= sie_rx_toggle_i; // see RULE11
                    count_q[e][`EPR_CNT_VALID_BIT] <= sie_crc_ok_i; // see RULE10
                    count_q[e][5:0] <= sie_rx_bytes_i + `EPR_CNT_CRC_BYTES; // see RULE9
                end
                else if (do_write && wstrb0_q && wsel.kind == usb_epregs_pkg::reg_count
                    && wsel.slot == 3'(e) && !count_lock_q[e]) // see RULE21
                begin
                    // Firmware sets toggle and IN count directly
                    count_q[e] <= wdata_q; // see RULE11
                end
            end
        end
    end

    // Locks: the lock set by an update wins over a read in the same cycle
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            mode_lock_q <= '0;
            count_lock_q <= '0;
            update_pending_q <= '0;
        end
        else if (ce_i)
        begin
            for (int e = 0; e < NUM_EP; e++)
            begin
                if (sie_update_i && sie_ep_i == 3'(e))
                begin
                    update_pending_q[e] <= 1'b0;
                end
                else if (sie_setup_i && sie_ep_i == 3'(e) && is_control(3'(e), five_ep))
                begin
                    update_pending_q[e] <= 1'b1;
                end
                if (sie_update_i && sie_ep_i == 3'(e) && is_control(3'(e), five_ep))
                begin
                    mode_lock_q[e] <= 1'b1; // see RULE17
                end
                else if (do_read && rsel.kind == usb_epregs_pkg::reg_mode
                    && rsel.slot == 3'(e) && !update_pending_q[e])
                begin
                    mode_lock_q[e] <= 1'b0; // see RULE14
                end
                if (sie_update_i && sie_ep_i == 3'(e) && rx_token
                    && is_control(3'(e), five_ep))
                begin
                    count_lock_q[e] <= 1'b1; // see RULE12
                end
                else if (do_read && rsel.kind == usb_epregs_pkg::reg_count
                    && rsel.slot == 3'(e) && !update_pending_q[e])
                begin
                    count_lock_q[e] <= 1'b0; // see RULE14
                end
            end
        end
    end

    // Setup bit held against clears until the control write data phase ends
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            setup_force_q <= '0;
        end
        else if (ce_i)
        begin
            for (int e = 0; e < NUM_EP; e++)
            begin
                if (sie_setup_i && sie_ep_i == 3'(e) && is_control(3'(e), five_ep))
                begin
                    setup_force_q[e] <= 1'b1; // see RULE13
                end
                else if (sie_data_end_i)
                begin
                    setup_force_q[e] <= 1'b0;
                end
            end
        end
    end

    // Endpoint interrupt flags, write one to clear; a new event wins
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            irq_q <= '0;
        end
        else if (ce_i)
        begin
            for (int e = 0; e < NUM_EP; e++)
            begin
                if (sie_update_i && sie_ep_i == 3'(e)
                    && (sie_irq_i || (rx_token && !sie_crc_ok_i)))
                begin
                    irq_q[e] <= 1'b1; // see RULE16
                end
                else if (do_write && wstrb0_q && wsel.kind == usb_epregs_pkg::reg_irq
                    && wdata_q[e])
                begin
                    irq_q[e] <= 1'b0;
                end
            end
        end
    end

    // Stall answers are registered, one cycle behind the mode registers
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            stall_in_o <= '0;
            stall_out_o <= '0;
        end
        else if (ce_i)
        begin
            for (int e = 0; e < NUM_EP; e++)
            begin
                stall_in_o[e] <= !is_control(3'(e), five_ep) && mode_q[e][`EPR_MODE_STALL_BIT]
                    && mode_q[e][3:0] == `EPR_MODE_ACK_OUT; // see RULE4
                stall_out_o[e] <= !is_control(3'(e), five_ep) && mode_q[e][`EPR_MODE_STALL_BIT]
                    && mode_q[e][3:0] == `EPR_MODE_ACK_IN; // see RULE4
            end
        end
    end

    always_comb
    begin
        for (int e = 0; e < NUM_EP; e++)
        begin
            ep_mode_o[8*e +: 8] = mode_q[e];
            ep_count_o[8*e +: 8] = count_q[e];
        end
    end

    assign ep_irq_flag_o = irq_q;
    assign five_ep_o = five_ep;
    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o = wready_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_arready_o = arready_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o = rdata_q;
    assign s_axi_rresp_o = rresp_q;

endmodule // usb_endpoint_mode_count_regs

/* File: rtl/usb_epregs_defs.svh */
`ifndef USB_EPREGS_DEFS_SVH
`define USB_EPREGS_DEFS_SVH

// Register indices; byte address is four times the index
`define EPR_IDX_COUNT_A 8'h11
`define EPR_IDX_MODE_EP0 8'h12
`define EPR_IDX_COUNT_B 8'h13
`define EPR_IDX_MODE_A 8'h14
`define EPR_IDX_COUNT_C 8'h15
`define EPR_IDX_MODE_B 8'h16
`define EPR_IDX_CONFIG 8'h1f
`define EPR_IDX_IRQ_FLAGS 8'h20
`define EPR_IDX_COUNT_D 8'h41
`define EPR_IDX_MODE_ALT_EP3 8'h42
`define EPR_IDX_COUNT_E 8'h43
`define EPR_IDX_MODE_C 8'h44

// Mode register fields
`define EPR_MODE_STALL_BIT 7
`define EPR_MODE_SETUP_BIT 7
`define EPR_MODE_IN_RX_BIT 6
`define EPR_MODE_OUT_RX_BIT 5
`define EPR_MODE_ACK_BIT 4
`define EPR_MODE_RESET 8'h00

// Counter register fields
`define EPR_CNT_TOGGLE_BIT 7
`define EPR_CNT_VALID_BIT 6
`define EPR_CNT_RESET 8'h00
`define EPR_CNT_CRC_BYTES 6'h02

// Mode encodings
`define EPR_MODE_NAK_INOUT 4'h1
`define EPR_MODE_NAK_OUT 4'h8
`define EPR_MODE_ACK_OUT 4'h9
`define EPR_MODE_ACK_OUT_STATUS_IN 4'hb
`define EPR_MODE_NAK_IN 4'hc
`define EPR_MODE_ACK_IN 4'hd
`define EPR_MODE_ACK_IN_STATUS_OUT 4'hf

// Endpoint configuration field (bits 7:6); bit 6 high means five endpoints
`define EPR_CFG_FIVE_EP_BIT 6
`define EPR_CFG_RESET 8'h00

`define EPR_RESP_OKAY 2'h0
`define EPR_RESP_SLVERR 2'h2

`endif

/* File: rtl/usb_epregs_pkg.sv */
package usb_epregs_pkg;

    typedef enum logic [1:0] {
        token_out,
        token_in,
        token_setup
    } sie_token_type;

    typedef enum logic [2:0] {
        reg_none,
        reg_mode,
        reg_count,
        reg_config,
        reg_irq
    } reg_kind_type;

    typedef struct packed {
        reg_kind_type kind;
        logic [2:0] slot;
    } reg_sel_type;

endpackage

/* File: tb/usb_epregs_sva.sv */
`timescale 1ns/100ps
module usb_epregs_sva #(
    parameter int NUM_EP = 5
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic sie_setup_i,
    input wire logic sie_data_end_i,
    input wire logic sie_update_i,
    input wire logic [2:0] sie_ep_i,
    input wire usb_epregs_pkg::sie_token_type sie_token_i,
    input wire logic sie_ack_i,
    input wire logic sie_crc_ok_i,
    input wire logic [5:0] sie_rx_bytes_i,
    input wire logic sie_rx_toggle_i,
    input wire logic sie_irq_i,
    input wire logic [8*NUM_EP-1:0] ep_mode_o,
    input wire logic [8*NUM_EP-1:0] ep_count_o,
    input wire logic [NUM_EP-1:0] stall_in_o,
    input wire logic [NUM_EP-1:0] stall_out_o,
    input wire logic [NUM_EP-1:0] ep_irq_flag_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic force_q;
    // Mirrors the setup force window
    always_ff @(posedge clk_sys_i)
        force_q <= !rst_i && !sie_data_end_i && (force_q || (sie_setup_i && sie_ep_i == 3'h0));
    sequence s_upd1;
        sie_update_i && sie_ep_i == 3'h1;
    endsequence
    sequence s_rx1;
        s_upd1 ##0 sie_token_i != usb_epregs_pkg::token_in;
    endsequence
    AST_RESET: assert property (disable iff (1'b0) rst_i |=> ep_mode_o == '0 && ep_count_o == '0)
        else $error("registers not cleared by reset");
    AST_COUNT: assert property (s_rx1 |=> ep_count_o[15:8] ==
        $past({sie_rx_toggle_i, sie_crc_ok_i, sie_rx_bytes_i + 6'h02}))
        else $error("counter not loaded from received packet");
    AST_ACK_IN: assert property (s_upd1 ##0 sie_ack_i && ep_mode_o[11:8] == 4'hd
        |=> ep_mode_o[11:8] == 4'hc && ep_mode_o[12])
        else $error("ack-in not turned to nak-in");
    AST_IRQ_SET: assert property (s_upd1 ##0 sie_irq_i |=> ep_irq_flag_o[1])
        else $error("interrupt flag missing after update");
    AST_IRQ_WHEN: assert property ($rose(ep_irq_flag_o[1]) |-> $past(sie_update_i))
        else $error("interrupt flag set without update");
    AST_STALL_IN: assert property (stall_in_o[1] ==
        $past(ep_mode_o[15] && ep_mode_o[11:8] == 4'h9))
        else $error("stall in output wrong");
    AST_STALL_OUT: assert property (stall_out_o[1] ==
        $past(ep_mode_o[15] && ep_mode_o[11:8] == 4'hd))
        else $error("stall out output wrong");
    AST_SETUP: assert property (force_q |-> ep_mode_o[7])
        else $error("setup bit dropped while forced");
    AST_NO_EARLY: assert property (sie_setup_i && !sie_update_i |=> $stable(ep_irq_flag_o))
        else $error("interrupt flag changed at setup point");
endmodule // usb_epregs_sva
bind usb_endpoint_mode_count_regs usb_epregs_sva #(.NUM_EP(NUM_EP)) chk_i (.*);

/* File: tb/sie_host_model.sv */
`timescale 1ns/100ps
module sie_host_model (
    input wire logic clk_sys_i,
    output logic setup_o,
    output logic data_end_o,
    output logic update_o,
    output logic [2:0] ep_o,
    output usb_epregs_pkg::sie_token_type token_o,
    output logic ack_o,
    output logic crc_ok_o,
    output logic [5:0] bytes_o,
    output logic toggle_o,
    output logic irq_o
);
    initial
    begin
        {setup_o, data_end_o, update_o, ep_o, ack_o, crc_ok_o, bytes_o, toggle_o, irq_o} = '0;
        token_o = usb_epregs_pkg::token_in;
    end
    task automatic pulse_setup(input logic [2:0] e);
        @(posedge clk_sys_i);
        ep_o <= e;
        setup_o <= 1'b1;
        @(posedge clk_sys_i);
        setup_o <= 1'b0;
        ep_o <= ~e;
    endtask
    task automatic pulse_end();
        @(posedge clk_sys_i);
        data_end_o <= 1'b1;
        @(posedge clk_sys_i);
        data_end_o <= 1'b0;
    endtask
    task automatic upd(input logic [2:0] e, input usb_epregs_pkg::sie_token_type t,
        input logic a, input logic c, input logic [5:0] n, input logic g, input logic q);
        @(posedge clk_sys_i);
        {ep_o, token_o, ack_o, crc_ok_o, bytes_o, toggle_o, irq_o} <= {e, t, a, c, n, g, q};
        update_o <= 1'b1;
        @(posedge clk_sys_i);
        update_o <= 1'b0;
        // Stale qualifiers would hide a sampling slip
        {ep_o, ack_o, crc_ok_o, bytes_o, toggle_o} <= ~{e, a, c, n, g};
    endtask
endmodule // sie_host_model

/* File: tb/usb_endpoint_mode_count_regs_bench.sv */
`timescale 1ns/100ps
module usb_endpoint_mode_count_regs_bench;
    localparam int NUM_EP = 5;
    logic clk_sys_i, rst_i, ce_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
    logic s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    logic s_axi_arready_o, s_axi_rvalid_o, five_ep_o;
    logic [9:0] s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, d;
    logic [3:0] s_axi_wstrb_i;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
    logic sie_setup_i, sie_data_end_i, sie_update_i, sie_ack_i, sie_crc_ok_i;
    logic sie_rx_toggle_i, sie_irq_i;
    logic [2:0] sie_ep_i;
    logic [5:0] sie_rx_bytes_i;
    usb_epregs_pkg::sie_token_type sie_token_i;
    logic [8*NUM_EP-1:0] ep_mode_o, ep_count_o;
    logic [NUM_EP-1:0] stall_in_o, stall_out_o, ep_irq_flag_o;
    int n_errors = 0;
    int n_checks = 0;
    // Index, write value, read back, response
    logic [25:0] rows [10] = '{{8'h11, 8'ha0, 8'ha0, 2'h0}, {8'h13, 8'h05, 8'h05, 2'h0},
        {8'h14, 8'h8d, 8'h8d, 2'h0}, {8'h15, 8'h00, 8'h00, 2'h0}, {8'h16, 8'h09, 8'h09, 2'h0},
        {8'h41, 8'h60, 8'h60, 2'h0}, {8'h42, 8'h09, 8'h09, 2'h0}, {8'h43, 8'h40, 8'h40, 2'h0},
        {8'h44, 8'h0c, 8'h0c, 2'h0}, {8'h30, 8'h55, 8'h00, 2'h2}};
    usb_endpoint_mode_count_regs #(.NUM_EP(NUM_EP)) DUT (.*);
    sie_host_model eng (.clk_sys_i(clk_sys_i), .setup_o(sie_setup_i), .data_end_o(sie_data_end_i),
        .update_o(sie_update_i), .ep_o(sie_ep_i), .token_o(sie_token_i), .ack_o(sie_ack_i),
        .crc_ok_o(sie_crc_ok_i), .bytes_o(sie_rx_bytes_i), .toggle_o(sie_rx_toggle_i),
        .irq_o(sie_irq_i));
    initial
    begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        n_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] v);
        logic b;
        b = 1'b0;
        @(posedge clk_sys_i);
        s_axi_awaddr_i <= {i, 2'h0};
        s_axi_wdata_i <= {24'h0, v};
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
        while (!b)
        begin
            @(posedge clk_sys_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            if (s_axi_bvalid_o)
            begin
                r = s_axi_bresp_o;
                b = 1'b1;
                s_axi_bready_i <= 1'b0;
            end
        end
    endtask
    task automatic rd(input logic [7:0] i);
        logic b;
        b = 1'b0;
        @(posedge clk_sys_i);
        s_axi_araddr_i <= {i, 2'h0};
        {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
        while (!b)
        begin
            @(posedge clk_sys_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o)
            begin
                {d, r} = {s_axi_rdata_o, s_axi_rresp_o};
                b = 1'b1;
                s_axi_rready_i <= 1'b0;
            end
        end
    endtask
    task automatic rc(input logic [7:0] i, input logic [7:0] e);
        rd(i);
        chk(40'(d), 40'(e));
    endtask
    initial
    begin
        {rst_i, ce_i, s_axi_wstrb_i} = 6'h31;
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        chk({ep_mode_o[7:0], ep_count_o[7:0], stall_in_o, stall_out_o, ep_irq_flag_o}, 40'h0);
        for (int k = 0; k < 10; k++)
        begin
            rc(rows[k][25:18], 8'h00);
            wr(rows[k][25:18], rows[k][17:10]);
            chk(40'(r), 40'(rows[k][1:0]));
            rc(rows[k][25:18], rows[k][9:2]);
            chk(40'(r), 40'(rows[k][1:0]));
        end
        chk(40'(stall_out_o), 40'h2);
        chk(40'(stall_in_o), 40'h0);
        eng.upd(3'h1, usb_epregs_pkg::token_out, 1'b1, 1'b1, 6'h08, 1'b1, 1'b1);
        rc(8'h14, 8'h9c);
        rc(8'h13, 8'hca);
        chk(40'(ep_irq_flag_o), 40'h2);
        eng.upd(3'h2, usb_epregs_pkg::token_out, 1'b0, 1'b0, 6'h00, 1'b0, 1'b0);
        rc(8'h15, 8'h02);
        chk(40'(ep_irq_flag_o), 40'h6);
        eng.upd(3'h2, usb_epregs_pkg::token_in, 1'b1, 1'b1, 6'h05, 1'b1, 1'b0);
        rc(8'h15, 8'h02);
        rc(8'h16, 8'h18);
        eng.upd(3'h0, usb_epregs_pkg::token_out, 1'b1, 1'b1, 6'h04, 1'b1, 1'b1);
        eng.pulse_setup(3'h0);
        rc(8'h11, 8'hc6);
        wr(8'h11, 8'h07);
        rc(8'h11, 8'hc6);
        eng.upd(3'h0, usb_epregs_pkg::token_setup, 1'b1, 1'b1, 6'h08, 1'b0, 1'b1);
        rc(8'h12, 8'h91);
        rc(8'h11, 8'h4a);
        wr(8'h12, 8'h00);
        rc(8'h12, 8'h80);
        eng.pulse_end();
        wr(8'h12, 8'h00);
        rc(8'h12, 8'h00);
        wr(8'h11, 8'h05);
        rc(8'h11, 8'h05);
        wr(8'h1f, 8'h40);
        wr(8'h42, 8'h8d);
        rc(8'h42, 8'h8d);
        chk({five_ep_o, 34'h0, stall_out_o}, {1'b1, 34'h0, 5'h08});
        give_verdict();
    end
    // Whole run is a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        n_errors++;
        give_verdict();
    end
endmodule // usb_endpoint_mode_count_regs_bench
